// >>> rtl/psd_consts.vh
// Constants for the PWM shutdown and dead-band controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a 32-bit classic Wishbone slave with byte addresses and 8-bit registers.
`ifndef PSD_CONSTS_VH
`define PSD_CONSTS_VH

// Register byte offsets
`define PSD_ADR_DEADBAND_RESTART 8'h00
`define PSD_ADR_AUTO_SHUTDOWN 8'h04
`define PSD_ADR_MODE_CONTROL 8'h08
`define PSD_ADR_DUTY_HIGH 8'h0c
`define PSD_ADR_PERIOD 8'h10
`define PSD_ADR_TIMER_CTRL 8'h14
`define PSD_ADR_PIN_DIR 8'h18
`define PSD_ADR_TIMER_COUNT 8'h1c

// Reset values
`define PSD_RST_ZERO 8'h00
`define PSD_RST_PERIOD 8'hff
`define PSD_RST_PIN_DIR 4'hf

// Field positions
`define PSD_BIT_RESTART 7
`define PSD_BIT_STATUS 7
`define PSD_BIT_TIMER_ON 0
`define PSD_BIT_TIMER_FLAG 7
`define PSD_BIT_POL_AC 1
`define PSD_BIT_POL_BD 0
`define PSD_PWM_MODE 2'h3

// Core clocks per instruction cycle, and the last value of the 2-bit phase counter
`define PSD_TCY_CLKS 4
`define PSD_PHASE_LAST 2'h3

// Read value for an unmapped address
`define PSD_UNMAPPED 32'h00000000

`endif

// >>> rtl/psd_ctrl.v
// PWM output stage control: dead-band insertion, auto-shutdown with safe pin
// states, polarity, 10-bit duty against an internal period timer, sleep freeze.
// Assumes clk_i is the oscillator clock; inputs arrive synchronous to it except
// the shutdown sources, which are resynchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "psd_consts.vh"

module psd_ctrl #(
  parameter HAS_BRIDGE = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire fault_input_n_i,
  input wire cmp1_i,
  input wire cmp2_i,
  input wire sleep_i,
  input wire pm_mode_i,
  input wire pm_tick_i,
  output wire out_a_o,
  output wire out_a_oe_n_o,
  output wire out_b_o,
  output wire out_b_oe_n_o,
  output wire out_c_o,
  output wire out_c_oe_n_o,
  output wire out_d_o,
  output wire out_d_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  reg restart_enable_q;
  reg [6:0] deadband_count_q;
  reg shutdown_status_q;
  reg [2:0] shutdown_source_select_q;
  reg [1:0] pair_ac_shutdown_state_q;
  reg [1:0] pair_bd_shutdown_state_q;
  reg [7:0] pwm_mode_control_q;
  reg [7:0] duty_high_byte_q;
  reg [7:0] period_register_q;
  reg timer_on_q;
  reg period_timer_flag_q;
  reg [3:0] pin_direction_q;
  reg [7:0] period_timer_q;
  reg [1:0] phase_q;
  reg [9:0] duty_latched_q;
  reg sd_hold_q;
  reg hw_caused_q;
  reg pwm_q;
  reg pwm_prev_q;
  reg [6:0] db_a_q;
  reg [6:0] db_b_q;
  reg ack_q;
  reg [31:0] rdata_q;
  reg cmp1_s1_q;
  reg cmp1_s2_q;
  reg cmp2_s1_q;
  reg cmp2_s2_q;
  reg flt_s1_q;
  reg flt_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Source select decode; bit0 comparator 1, bit1 comparator 2, bit2 fault
  function cause_of;
    input [2:0] sel;
    input c1;
    input c2;
    input flt;
    begin
      cause_of = (sel[0] & c1) | (sel[1] & c2) | (sel[2] & flt);
    end
  endfunction

  // Dead-band counter step: reload on a rise, count down per instruction cycle
  function [6:0] db_next;
    input [6:0] cnt;
    input [6:0] load_val;
    input rise;
    input tcy;
    begin
      if (rise)
        db_next = load_val;
      else if (tcy && cnt != 7'h00)
        db_next = cnt - 7'h01;
      else
        db_next = cnt;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational terms
  wire run_w = ~sleep_i; // Sleep freezes the divider, timer, status and PWM state below; bus registers and synchronisers still run
  wire tcy_en = run_w && (phase_q == `PSD_PHASE_LAST);
  wire timer_tick = run_w && timer_on_q && (pm_mode_i ? pm_tick_i : tcy_en);
  wire period_end = timer_tick && (period_timer_q == period_register_q);
  wire pwm_enabled = (pwm_mode_control_q[3:2] == `PSD_PWM_MODE);
  wire [6:0] db_eff = (HAS_BRIDGE != 0) ? deadband_count_q : 7'h00;
  // Raw cause drives the pins at once; synced cause drives the status bit
  wire cause_raw = cause_of(shutdown_source_select_q, cmp1_i, cmp2_i, ~fault_input_n_i);
  wire cause_sync = cause_of(shutdown_source_select_q, cmp1_s2_q, cmp2_s2_q, flt_s2_q);
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  wire [7:0] wbyte = wb_dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Source synchronisers; first stages feed only the second stages
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmp1_s1_q <= 1'b0;
      cmp1_s2_q <= 1'b0;
      cmp2_s1_q <= 1'b0;
      cmp2_s2_q <= 1'b0;
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
    end
    else
    begin
      cmp1_s1_q <= cmp1_i;
      cmp1_s2_q <= cmp1_s1_q;
      cmp2_s1_q <= cmp2_i;
      cmp2_s2_q <= cmp2_s1_q;
      flt_s1_q <= ~fault_input_n_i;
      flt_s2_q <= flt_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers other than the status bit and timer flag
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      restart_enable_q <= 1'b0;
      deadband_count_q <= 7'h00;
      shutdown_source_select_q <= 3'h0;
      pair_ac_shutdown_state_q <= 2'h0;
      pair_bd_shutdown_state_q <= 2'h0;
      pwm_mode_control_q <= `PSD_RST_ZERO;
      duty_high_byte_q <= `PSD_RST_ZERO;
      period_register_q <= `PSD_RST_PERIOD;
      timer_on_q <= 1'b0;
      pin_direction_q <= `PSD_RST_PIN_DIR;
    end
    else if (bus_wr)
    begin
      case (wb_adr_i)
        `PSD_ADR_DEADBAND_RESTART:
        begin
          restart_enable_q <= wbyte[`PSD_BIT_RESTART];
          deadband_count_q <= (HAS_BRIDGE != 0) ? wbyte[6:0] : 7'h00;
        end
        `PSD_ADR_AUTO_SHUTDOWN:
        begin
          shutdown_source_select_q <= wbyte[6:4];
          pair_ac_shutdown_state_q <= wbyte[3:2];
          pair_bd_shutdown_state_q <= (HAS_BRIDGE != 0) ? wbyte[1:0] : 2'h0;
        end
        `PSD_ADR_MODE_CONTROL: pwm_mode_control_q <= wbyte;
        `PSD_ADR_DUTY_HIGH: duty_high_byte_q <= wbyte;
        `PSD_ADR_PERIOD: period_register_q <= wbyte;
        `PSD_ADR_TIMER_CTRL: timer_on_q <= wbyte[`PSD_BIT_TIMER_ON];
        `PSD_ADR_PIN_DIR: pin_direction_q <= wbyte[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown status: hardware set wins over any software clear
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shutdown_status_q <= 1'b0;
      hw_caused_q <= 1'b0;
    end
    else if (run_w)
    begin
      if (cause_sync)
      begin
        shutdown_status_q <= 1'b1;
        hw_caused_q <= 1'b1;
      end
      else if (bus_wr && wb_adr_i == `PSD_ADR_AUTO_SHUTDOWN)
      begin
        // Write only reaches here with no cause active
        shutdown_status_q <= wbyte[`PSD_BIT_STATUS];
        hw_caused_q <= 1'b0;
      end
      else if (restart_enable_q && hw_caused_q)
      begin
        // A forced shutdown is not auto-cleared, or forcing would be useless
        shutdown_status_q <= 1'b0;
        hw_caused_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction-cycle divider, period timer and period flag
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q <= 2'h0;
      period_timer_q <= 8'h00;
      duty_latched_q <= 10'h000;
      period_timer_flag_q <= 1'b0;
      sd_hold_q <= 1'b0;
    end
    else
    begin
      if (run_w)
        phase_q <= phase_q + 2'h1;
      if (period_end)
      begin
        period_timer_q <= 8'h00;
        duty_latched_q <= {duty_high_byte_q, pwm_mode_control_q[5:4]};
        // Safe state is released only here, never mid-period
        sd_hold_q <= shutdown_status_q | cause_sync;
      end
      else
      begin
        if (timer_tick)
          period_timer_q <= period_timer_q + 8'h01;
        if (run_w && (shutdown_status_q | cause_sync))
          sd_hold_q <= 1'b1;
      end
      // First rollover marks the start of the second period
      if (period_end)
        period_timer_flag_q <= 1'b1;
      else if (bus_wr && wb_adr_i == `PSD_ADR_TIMER_CTRL && wbyte[`PSD_BIT_TIMER_FLAG])
        period_timer_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM compare and dead-band counters
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_q <= 1'b0;
      pwm_prev_q <= 1'b0;
      db_a_q <= 7'h00;
      db_b_q <= 7'h00;
    end
    else if (run_w)
    begin
      // Compare at oscillator resolution: timer plus divider phase
      pwm_q <= pwm_enabled && timer_on_q && ({period_timer_q, phase_q} < duty_latched_q);
      pwm_prev_q <= pwm_q;
      db_a_q <= db_next(db_a_q, db_eff, pwm_q & ~pwm_prev_q, tcy_en);
      db_b_q <= db_next(db_b_q, db_eff, ~pwm_q & pwm_prev_q, tcy_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: half-bridge pair, polarity, then asynchronous safe override
  wire act_a = pwm_q && (db_a_q == 7'h00) && !(pwm_q & ~pwm_prev_q && db_eff != 7'h00);
  wire act_b = pwm_enabled && !pwm_q && (db_b_q == 7'h00) && !(~pwm_q & pwm_prev_q && db_eff != 7'h00);
  wire lvl_ac = act_a ^ pwm_mode_control_q[`PSD_BIT_POL_AC];
  wire lvl_bd = act_b ^ pwm_mode_control_q[`PSD_BIT_POL_BD];
  wire shut = shutdown_status_q | sd_hold_q | cause_raw;
  wire sd_ac = pair_ac_shutdown_state_q[0];
  wire sd_bd = pair_bd_shutdown_state_q[0];
  wire sd_ac_z = shut && pair_ac_shutdown_state_q[1];
  wire sd_bd_z = shut && pair_bd_shutdown_state_q[1];

  // Pins hold their value through sleep while the raw cause and the bus stay quiet; the other sources are frozen
  assign out_a_o = shut ? sd_ac : lvl_ac;
  assign out_c_o = shut ? sd_ac : lvl_ac;
  assign out_b_o = shut ? sd_bd : lvl_bd;
  assign out_d_o = shut ? sd_bd : lvl_bd;
  assign out_a_oe_n_o = pin_direction_q[0] | sd_ac_z;
  assign out_b_oe_n_o = pin_direction_q[1] | sd_bd_z;
  assign out_c_oe_n_o = pin_direction_q[2] | sd_ac_z;
  assign out_d_oe_n_o = pin_direction_q[3] | sd_bd_z;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack for one cycle, data registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= bus_req;
      if (bus_req)
      begin
        case (wb_adr_i)
          `PSD_ADR_DEADBAND_RESTART: rdata_q <= {24'h000000, restart_enable_q, db_eff};
          `PSD_ADR_AUTO_SHUTDOWN:
            rdata_q <= {24'h000000, shutdown_status_q, shutdown_source_select_q,
                        pair_ac_shutdown_state_q, pair_bd_shutdown_state_q};
          `PSD_ADR_MODE_CONTROL: rdata_q <= {24'h000000, pwm_mode_control_q};
          `PSD_ADR_DUTY_HIGH: rdata_q <= {24'h000000, duty_high_byte_q};
          `PSD_ADR_PERIOD: rdata_q <= {24'h000000, period_register_q};
          `PSD_ADR_TIMER_CTRL: rdata_q <= {24'h000000, period_timer_flag_q, 6'h00, timer_on_q};
          `PSD_ADR_PIN_DIR: rdata_q <= {28'h0000000, pin_direction_q};
          `PSD_ADR_TIMER_COUNT: rdata_q <= {24'h000000, period_timer_q};
          default: rdata_q <= `PSD_UNMAPPED;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule // psd_ctrl

`default_nettype wire

// >>> testbench/psd_monitor.sv
// Checker for the PWM shutdown controller, watching only its ports.
// Assumes one clock, synchronous active-high reset and classic Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "psd_consts.vh"

module psd_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire fault_input_n_i,
  input wire cmp1_i,
  input wire cmp2_i,
  input wire sleep_i,
  input wire out_a_o,
  input wire out_a_oe_n_o,
  input wire out_b_o,
  input wire out_b_oe_n_o,
  input wire out_c_o,
  input wire out_c_oe_n_o,
  input wire out_d_o,
  input wire out_d_oe_n_o
);
  logic [6:0] cfg_q;
  wire logic cause;

  ////////////////////////////////////////////////////////////////////////
  // Shadow of source and safe-state fields, taken at the same edge as the design
  always_ff @(posedge clk_i)
    if (rst_i)
      cfg_q <= 7'h00;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == `PSD_ADR_AUTO_SHUTDOWN)
      cfg_q <= wb_dat_i[6:0];

  // Raw cause, unsynchronised, because pin forcing must not wait for a clock
  assign cause = (cfg_q[4] & cmp1_i) | (cfg_q[5] & cmp2_i) | (cfg_q[6] & ~fault_input_n_i);

  ////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack_timing; s_req |=> s_ack; endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("ack not one pulse after request");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rd_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
  property p_rst_pins; $fell(rst_i) |-> !wb_ack_o && out_a_oe_n_o && out_b_oe_n_o && out_c_oe_n_o && out_d_oe_n_o;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins driven after reset");
  property p_pairs; out_a_o == out_c_o && out_b_o == out_d_o; endproperty
  a_pairs: assert property (p_pairs) else $error("pin pair levels differ");
  property p_sleep_hold; sleep_i && $past(sleep_i) && !$past(wb_stb_i) && $stable(cause) |-> $stable({out_a_o, out_b_o});
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("pins moved in sleep");
  property p_ac_float; cause && cfg_q[3] |-> out_a_oe_n_o && out_c_oe_n_o; endproperty
  a_ac_float: assert property (p_ac_float) else $error("pair AC not floated");
  property p_bd_float; cause && cfg_q[1] |-> out_b_oe_n_o && out_d_oe_n_o; endproperty
  a_bd_float: assert property (p_bd_float) else $error("pair BD not floated");
  property p_bd_level; cause && !cfg_q[1] |-> out_b_o == cfg_q[0] && out_d_o == cfg_q[0]; endproperty
  a_bd_level: assert property (p_bd_level) else $error("pair BD not at safe level");
endmodule // psd_monitor

bind psd_ctrl psd_monitor psd_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .fault_input_n_i(fault_input_n_i), .cmp1_i(cmp1_i), .cmp2_i(cmp2_i), .sleep_i(sleep_i),
  .out_a_o(out_a_o), .out_a_oe_n_o(out_a_oe_n_o), .out_b_o(out_b_o), .out_b_oe_n_o(out_b_oe_n_o),
  .out_c_o(out_c_o), .out_c_oe_n_o(out_c_oe_n_o), .out_d_o(out_d_o), .out_d_oe_n_o(out_d_oe_n_o));
`default_nettype wire

// >>> testbench/psd_bridge_model.sv
// Switch-driver inputs of the external bridge, with board pull-downs.
// Assumes pin bit 0 is A up to bit 3 for D, enables active low.
`timescale 1ns/100ps
`default_nettype none

module psd_bridge_model (
  input wire logic [3:0] pin_i,
  input wire logic [3:0] oe_n_i,
  output logic [3:0] lvl_o
);
  // A floating pin reads low, so a switch stays off when nobody drives it
  assign lvl_o = pin_i & ~oe_n_i;
endmodule // psd_bridge_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the PWM shutdown controller.
// Assumes the design answers every bus request and resets synchronously.
`timescale 1ns/100ps
`default_nettype none
`include "psd_consts.vh"

module tb_top;
  logic clk_i;
  logic rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, flt_n = 1'b1, c1 = 1'b0, c2 = 1'b0, slp = 1'b0;
  logic pmm = 1'b0, pmt = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] q8;
  logic [1:0] st;
  logic [31:0] wdat = 32'h00000000, rs = 32'h0000d230;
  wire [31:0] rdat;
  wire ack, oa, oan, ob, obn, oc, ocn, od, odn;
  wire [3:0] lvl;
  int num_checks = 0, miscompares = 0, cyc_cnt = 0, s, k;
  int regm[8];

  psd_ctrl psd_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fault_input_n_i(flt_n), .cmp1_i(c1),
    .cmp2_i(c2), .sleep_i(slp), .pm_mode_i(pmm), .pm_tick_i(pmt), .out_a_o(oa), .out_a_oe_n_o(oan), .out_b_o(ob),
    .out_b_oe_n_o(obn), .out_c_o(oc), .out_c_oe_n_o(ocn), .out_d_o(od), .out_d_oe_n_o(odn));
  psd_bridge_model psd_bridge_model_i (.pin_i({od, oc, ob, oa}), .oe_n_i({odn, ocn, obn, oan}), .lvl_o(lvl));

  ////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a dead bus cannot hang the run
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers: pseudo-random source, compare, bus cycles
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until ack is sampled high; data taken at that edge only
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    regm[a[4:2]] = d;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`PSD_ADR_DEADBAND_RESTART, 8'h00);
    rd(`PSD_ADR_AUTO_SHUTDOWN, 8'h00);
    rd(`PSD_ADR_PERIOD, `PSD_RST_PERIOD);
    rd(`PSD_ADR_PIN_DIR, 8'h0f);
    rd(8'h20, 8'h00);
    // Random contents must read back whole, bridge bits included
    repeat (4)
    begin
      wr(`PSD_ADR_DEADBAND_RESTART, xs());
      wr(`PSD_ADR_DUTY_HIGH, xs());
      rd(`PSD_ADR_DEADBAND_RESTART, regm[0]);
      rd(`PSD_ADR_DUTY_HIGH, regm[3]);
    end
    // Short period running, PWM mode set, automatic restart on
    wr(`PSD_ADR_PERIOD, 8'h02);
    wr(`PSD_ADR_MODE_CONTROL, 8'h0c);
    wr(`PSD_ADR_DEADBAND_RESTART, 8'h83);
    wr(`PSD_ADR_TIMER_CTRL, 8'h01);
    rd(`PSD_ADR_TIMER_CTRL, 8'h01);
    // Pins stay inputs until the first period has run out, so no stale latch reaches the bridge
    do xfer(1'b0, `PSD_ADR_TIMER_CTRL, 8'h00, q8); while (!q8[7]);
    wr(`PSD_ADR_PIN_DIR, 8'h00);
    for (s = 0; s < 8; s++)
      for (k = 0; k < 3; k++)
      begin
        st = 2'(xs());
        wr(`PSD_ADR_AUTO_SHUTDOWN, {1'b0, s[2:0], 2'h3, st});
        c1 <= (k == 0);
        c2 <= (k == 1);
        flt_n <= (k != 2);
        @(posedge clk_i);
        @(negedge clk_i);
        chk("pin a float", {7'h00, s[k]}, {7'h00, oan});
        repeat (4) @(posedge clk_i);
        rd(`PSD_ADR_AUTO_SHUTDOWN, {s[k], s[2:0], 2'h3, st});
        c1 <= 1'b0;
        c2 <= 1'b0;
        flt_n <= 1'b1;
        repeat (20) @(posedge clk_i);
        rd(`PSD_ADR_AUTO_SHUTDOWN, {1'b0, s[2:0], 2'h3, st});
        chk("pin a driven", 8'h00, {7'h00, oan});
      end
    rd(`PSD_ADR_TIMER_CTRL, 8'h81);
    slp <= 1'b1;
    repeat (6) @(posedge clk_i);
    slp <= 1'b0;
    // Without restart the status waits for software
    wr(`PSD_ADR_DEADBAND_RESTART, 8'h00);
    wr(`PSD_ADR_AUTO_SHUTDOWN, 8'h4f);
    flt_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    wr(`PSD_ADR_AUTO_SHUTDOWN, 8'h4f);
    rd(`PSD_ADR_AUTO_SHUTDOWN, 8'hcf);
    flt_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd(`PSD_ADR_AUTO_SHUTDOWN, 8'hcf);
    wr(`PSD_ADR_AUTO_SHUTDOWN, 8'h4f);
    rd(`PSD_ADR_AUTO_SHUTDOWN, 8'h4f);
    // Software-forced shutdown drives each pair to its chosen level
    wr(`PSD_ADR_AUTO_SHUTDOWN, 8'h84);
    rd(`PSD_ADR_AUTO_SHUTDOWN, 8'h84);
    chk("levels ac", 8'h05, {4'h0, lvl});
    wr(`PSD_ADR_AUTO_SHUTDOWN, 8'h81);
    chk("levels bd", 8'h0a, {4'h0, lvl});
    chk("enables", 8'h00, {4'h0, odn, ocn, obn, oan});
    // Normal drive with zero duty: only the B/D pair is active, after a period start
    wr(`PSD_ADR_AUTO_SHUTDOWN, 8'h00);
    wr(`PSD_ADR_DUTY_HIGH, 8'h00);
    repeat (30) @(posedge clk_i);
    chk("levels run", 8'h0a, {4'h0, lvl});
    // Polarity is changed here with the pins set as inputs; the pin levels still show it
    wr(`PSD_ADR_PIN_DIR, 8'h0f);
    wr(`PSD_ADR_MODE_CONTROL, 8'h0f);
    chk("levels inverted", 8'h05, {4'h0, od, oc, ob, oa});
    // Power-managed clock: the timer moves on ticks only, not on the core clock
    pmm <= 1'b1;
    wr(`PSD_ADR_PERIOD, 8'h40);
    xfer(1'b0, `PSD_ADR_TIMER_COUNT, 8'h00, q8);
    repeat (3)
    begin
      pmt <= 1'b1;
      @(posedge clk_i);
      pmt <= 1'b0;
      @(posedge clk_i);
    end
    rd(`PSD_ADR_TIMER_COUNT, q8 + 8'h03);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
